// ### verilog/ccsm_defs.svh
// Purpose : offsets, fields, reset values of the set manager
// Assumes : included by every ccsm design file except the package
// Notes   : gain words are in 0.1 dB steps
`ifndef CCSM_DEFS_SVH
`define CCSM_DEFS_SVH
// ==========================================
// register offsets
`define CCSM_OFS_CTRL    8'h00
`define CCSM_OFS_FACT    8'h04
`define CCSM_OFS_BOOT    8'h08
`define CCSM_OFS_STAT    8'h0C
`define CCSM_OFS_PARAM   8'h40
`define CCSM_OFS_LUT     8'h80
// ==========================================
// field positions
`define CCSM_CTRL_STORE  4
`define CCSM_CTRL_RESTOR 5
`define CCSM_ST_BUSY     0
`define CCSM_ST_REJECT   1
`define CCSM_ST_BOOTED   2
`define CCSM_ST_IDLE     3
`define CCSM_ST_SRC      8
// ==========================================
// delivery values
`define CCSM_DLV_FACT    2'h0
`define CCSM_DLV_BOOT    2'h0
// ==========================================
// working-set word layout
`define CCSM_W_GAIN      0
`define CCSM_W_EXPO      1
`define CCSM_W_EXPAUTO   2
`define CCSM_W_GAINAUTO  3
`define CCSM_W_BALAUTO   4
`define CCSM_W_RED       5
`define CCSM_W_BLUE      6
// ==========================================
// factory profile contents
`define CCSM_GAIN_LOW    16'h0000
`define CCSM_GAIN_6DB    16'h003C
`define CCSM_EXPO_STD    16'h2710
`define CCSM_AUTO_OFF    16'h0000
`define CCSM_AUTO_CONT   16'h0002
`define CCSM_RATIO_ONE   16'h0100
`define CCSM_DAY_RED     16'h0180
`define CCSM_DAY_BLUE    16'h0140
`endif

// ### verilog/ccsm_pkg.sv
// Purpose : shared types of the set manager
// Assumes : nothing
// Notes   : set codes match the register encoding
package ccsm_pkg;
    // ==========================================
    // set and profile codes
    typedef enum logic [1:0] {
        CCSM_SET_DEFAULT = 2'h0,
        CCSM_SET_USER1   = 2'h1,
        CCSM_SET_USER2   = 2'h2,
        CCSM_SET_USER3   = 2'h3
    } ccsm_set_t;
    typedef enum logic [1:0] {
        CCSM_FP_STANDARD = 2'h0,
        CCSM_FP_HIGHGAIN = 2'h1,
        CCSM_FP_AUTO     = 2'h2,
        CCSM_FP_COLOR    = 2'h3
    } ccsm_factory_t;
    // ==========================================
    // transfer states, gray along idle paths
    typedef enum logic [2:0] {
        CCSM_S_IDLE = 3'h0,
        CCSM_S_LOAD = 3'h1,
        CCSM_S_SAVE = 3'h2,
        CCSM_S_BOOT = 3'h4
    } ccsm_state_t;
endpackage : ccsm_pkg

// ### verilog/ccsm_factory_rom.sv
// Purpose : fixed contents of the four factory profiles
// Assumes : pure lookup, no storage
// Notes   : unlisted words read zero
`timescale 1ns/1ps
`default_nettype none
`include "ccsm_defs.svh"
module ccsm_factory_rom
    import ccsm_pkg::*;
#(
    parameter int DW = 16,
    parameter int IW = 3
) (
    input  wire ccsm_factory_t profile,
    input  wire logic [IW-1:0] wordIdx,
    output logic [DW-1:0]      word
);
    // ==========================================
    // RULE4 low gain, autos off
    function automatic logic [DW-1:0] stdWord(input int i);
        case (i)
            `CCSM_W_GAIN: return DW'(`CCSM_GAIN_LOW);
            `CCSM_W_EXPO: return DW'(`CCSM_EXPO_STD);
            `CCSM_W_RED:  return DW'(`CCSM_RATIO_ONE);
            `CCSM_W_BLUE: return DW'(`CCSM_RATIO_ONE);
            default:      return DW'(`CCSM_AUTO_OFF);
        endcase
    endfunction : stdWord

    always_comb begin
        word = stdWord(int'(wordIdx));
        unique case (profile)
            CCSM_FP_STANDARD: begin
            end
            // RULE5 gain 6 dB
            CCSM_FP_HIGHGAIN: begin
                if (int'(wordIdx) == `CCSM_W_GAIN) begin
                    word = DW'(`CCSM_GAIN_6DB);
                end
            end
            // RULE6 auto exposure
            CCSM_FP_AUTO: begin
                if (int'(wordIdx) == `CCSM_W_EXPAUTO) begin
                    word = DW'(`CCSM_AUTO_CONT);
                end
            end
            CCSM_FP_COLOR: begin
                if (int'(wordIdx) == `CCSM_W_RED) begin
                    word = DW'(`CCSM_DAY_RED);
                end else if (int'(wordIdx) == `CCSM_W_BLUE) begin
                    word = DW'(`CCSM_DAY_BLUE);
                end
            end
        endcase
    end
endmodule : ccsm_factory_rom
`default_nettype wire

// ### verilog/ccsm_nv_store.sv
// Purpose : persistent cells: three user slots and two picks
// Assumes : format is a synchronised level
// Notes   : cells ignore resetn on purpose, they model flash
`timescale 1ns/1ps
`default_nettype none
`include "ccsm_defs.svh"
module ccsm_nv_store
    import ccsm_pkg::*;
#(
    parameter int DW        = 16,
    parameter int NUM_WORDS = 8,
    parameter int IW        = 3
) (
    input  wire logic          clk,
    input  wire logic          format,
    input  wire logic          wrEn,
    input  wire ccsm_set_t     wrSlot,
    input  wire logic [IW-1:0] wrIdx,
    input  wire logic [DW-1:0] wrData,
    input  wire ccsm_set_t     rdSlot,
    input  wire logic [IW-1:0] rdIdx,
    output logic [DW-1:0]      rdData,
    input  wire logic          factWr,
    input  wire ccsm_factory_t factIn,
    output ccsm_factory_t      factPick,
    input  wire logic          bootWr,
    input  wire ccsm_set_t     bootIn,
    output ccsm_set_t          bootPick
);
    logic [DW-1:0] mem [3][NUM_WORDS];

    function automatic logic [1:0] row(input ccsm_set_t s);
        return 2'(s) - 2'h1;
    endfunction : row

    // ==========================================
    // user slots
    always_ff @(posedge clk) begin
        if (wrEn && wrSlot != CCSM_SET_DEFAULT) begin
            mem[row(wrSlot)][wrIdx] <= wrData;
        end
    end
    assign rdData = (rdSlot == CCSM_SET_DEFAULT) ? '0 : mem[row(rdSlot)][rdIdx];

    // ==========================================
    // RULE8 format restores delivery picks
    always_ff @(posedge clk) begin
        if (format) begin
            factPick <= ccsm_factory_t'(`CCSM_DLV_FACT);
            bootPick <= ccsm_set_t'(`CCSM_DLV_BOOT);
        end else begin
            if (factWr) begin
                factPick <= factIn;
            end
            if (bootWr) begin
                bootPick <= bootIn;
            end
        end
    end
endmodule : ccsm_nv_store
`default_nettype wire

// ### verilog/ccsm_set_manager.sv
// Purpose : camera configuration-set manager
// Assumes : acquisition flags come from logic on clk
// Notes   : nvFormat is an async pin, brought in by two flops
//
// Summary of operation
// RULE1 - working set sits in plain flops, cleared by reset
// RULE2 - software parameter writes go only to the working set
// RULE3 - four factory profiles are fixed and never writable
// RULE4 - standard profile has low gain, all autos off
// RULE5 - high-gain profile equals standard but gain is 6 dB
// RULE6 - auto profile equals standard with continuous exposure auto
// RULE7 - software picks which factory profile is the default set
// RULE8 - delivery state points the default set at standard profile
// RULE9 - default-set pick accepted only when acquisition is idle
// RULE10 - default set can be loaded into the working set
// RULE11 - every reset loads the startup set into working set
// RULE12 - three persistent user slots numbered one to three
// RULE13 - store copies the whole working set over one slot
// RULE14 - software selects the slot before issuing store; code takes the slot from the CTRL write that carries store
// RULE15 - lookup table is never stored and clears at reset
// RULE16 - a user slot can be loaded into the working set
// RULE17 - software selects user or default set, then restore; code takes the set from the CTRL write that carries restore
// RULE18 - restore accepted only when acquisition is idle
// RULE19 - startup set is user one to three or default
// RULE20 - busy during transfers, new commands refused meanwhile
// RULE21 - startup pick is held in persistent storage
`timescale 1ns/1ps
`default_nettype none
`include "ccsm_defs.svh"
module ccsm_set_manager
    import ccsm_pkg::*;
#(
    parameter int DW        = 16,
    parameter int NUM_WORDS = 8,
    parameter int LUT_WORDS = 4
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              nvFormat,
    input  wire logic              acqContinuous,
    input  wire logic              acqPending,
    input  wire logic [7:0]        regAddr,
    input  wire logic [31:0]       regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic [31:0]            regRdData,
    output logic [NUM_WORDS*DW-1:0] activeSet,
    output logic [LUT_WORDS*DW-1:0] lutSet,
    output logic                   busy,
    output logic                   setValid
);
    localparam int IW = $clog2(NUM_WORDS);
    localparam int LW = $clog2(LUT_WORDS);

    // ==========================================
    // declarations
    ccsm_state_t   state_q;
    ccsm_state_t   state_d;
    logic [IW-1:0] idx_q;
    ccsm_set_t     xferSet_q;
    ccsm_set_t     activeSrc_q;
    logic          booted_q;
    logic          reject_q;
    ccsm_set_t     profileSlotPick_q;
    logic [DW-1:0] work_q [NUM_WORDS];
    logic [DW-1:0] lut_q [LUT_WORDS];
    logic          fmtMeta_q;
    logic          fmtSync_q;
    logic [31:0]   rdData_q;
    logic [31:0]   rdData_d;

    ccsm_factory_t factoryProfilePick;
    ccsm_set_t     bootProfilePick;
    ccsm_set_t     srcSet;
    logic [DW-1:0] romWord;
    logic [DW-1:0] nvWord;
    logic [DW-1:0] srcWord;
    logic          acqIdle;
    logic          lastIdx;
    logic          ctrlWr;
    ccsm_set_t     cmdSlot;
    logic          profileStoreCmd;
    logic          profileRestoreCmd;
    logic          storeGo;
    logic          restoreGo;
    logic          cmdReject;
    logic          factWr;
    logic          factGo;
    logic          bootWr;
    logic          bootGo;
    logic          paramWr;
    logic          paramGo;
    logic          lutWr;
    logic          rejectSet;
    logic          rejectClr;

    // ==========================================
    // helpers
    function automatic logic inWin(input logic [7:0] a,
                                   input logic [7:0] base,
                                   input int n);
        logic [7:0] d;
        d = a - base;
        return (a >= base) && (d[1:0] == 2'h0) && (int'(d[7:2]) < n);
    endfunction : inWin

    function automatic logic [5:0] wordOf(input logic [7:0] a,
                                          input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        return d[7:2];
    endfunction : wordOf

    // ==========================================
    // pin synchroniser
    always_ff @(posedge clk) begin
        fmtMeta_q <= nvFormat;
        fmtSync_q <= fmtMeta_q;
    end

    // ==========================================
    // persistent storage and factory profiles
    // RULE12 persistent user slots
    ccsm_nv_store #(
        .DW        (DW),
        .NUM_WORDS (NUM_WORDS),
        .IW        (IW)
    ) u_nv (
        .clk      (clk),
        .format   (fmtSync_q),
        .wrEn     (state_q == CCSM_S_SAVE),
        .wrSlot   (xferSet_q),
        .wrIdx    (idx_q),
        .wrData   (work_q[idx_q]),
        .rdSlot   (srcSet),
        .rdIdx    (idx_q),
        .rdData   (nvWord),
        .factWr   (factGo),
        .factIn   (ccsm_factory_t'(regWrData[1:0])),
        .factPick (factoryProfilePick),
        .bootWr   (bootGo),
        .bootIn   (ccsm_set_t'(regWrData[1:0])),
        .bootPick (bootProfilePick)
    );

    // RULE3 fixed read-only profiles
    ccsm_factory_rom #(
        .DW (DW),
        .IW (IW)
    ) u_rom (
        .profile (factoryProfilePick),
        .wordIdx (idx_q),
        .word    (romWord)
    );

    // ==========================================
    // command decode
    always_comb begin
        acqIdle           = !acqContinuous && !acqPending;
        busy              = state_q != CCSM_S_IDLE;
        lastIdx           = int'(idx_q) == NUM_WORDS - 1;
        ctrlWr            = regWr && regAddr == `CCSM_OFS_CTRL;
        cmdSlot           = ccsm_set_t'(regWrData[1:0]);
        profileStoreCmd   = ctrlWr && regWrData[`CCSM_CTRL_STORE];
        profileRestoreCmd = ctrlWr && regWrData[`CCSM_CTRL_RESTOR];
        // RULE20 one transfer at a time
        // RULE13 store needs a user slot
        storeGo   = profileStoreCmd && !profileRestoreCmd && !busy
                    && cmdSlot != CCSM_SET_DEFAULT;
        // RULE18 restore only when idle
        restoreGo = profileRestoreCmd && !profileStoreCmd && !busy && acqIdle;
        cmdReject = (profileStoreCmd && !storeGo)
                    || (profileRestoreCmd && !restoreGo);
        factWr    = regWr && regAddr == `CCSM_OFS_FACT;
        // RULE9 pick only while idle
        factGo    = factWr && acqIdle && !busy;
        bootWr    = regWr && regAddr == `CCSM_OFS_BOOT;
        // startup pick changing mid-boot would mix two sets
        bootGo    = bootWr && !busy;
        paramWr   = regWr && inWin(regAddr, `CCSM_OFS_PARAM, NUM_WORDS);
        paramGo   = paramWr && !busy;
        lutWr     = regWr && inWin(regAddr, `CCSM_OFS_LUT, LUT_WORDS);
        rejectSet = cmdReject || (factWr && !factGo) || (bootWr && !bootGo)
                    || (paramWr && !paramGo);
        rejectClr = regWr && regAddr == `CCSM_OFS_STAT
                    && regWrData[`CCSM_ST_REJECT];
    end

    // ==========================================
    // transfer source
    always_comb begin
        // RULE19 boot reads startup set
        srcSet  = (state_q == CCSM_S_BOOT) ? bootProfilePick : xferSet_q;
        // RULE10 default set from profiles
        srcWord = (srcSet == CCSM_SET_DEFAULT) ? romWord : nvWord;
    end

    // ==========================================
    // transfer state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CCSM_S_IDLE: begin
                if (storeGo) begin
                    state_d = CCSM_S_SAVE;
                end else if (restoreGo) begin
                    state_d = CCSM_S_LOAD;
                end
            end
            CCSM_S_LOAD, CCSM_S_SAVE, CCSM_S_BOOT: begin
                if (lastIdx) begin
                    state_d = CCSM_S_IDLE;
                end
            end
            default: begin
                state_d = CCSM_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            // RULE11 reset starts a boot load
            state_q <= CCSM_S_BOOT;
            idx_q   <= '0;
        end else begin
            state_q <= state_d;
            if (state_q != CCSM_S_IDLE && !lastIdx) begin
                idx_q <= idx_q + IW'(1);
            end else begin
                idx_q <= '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            xferSet_q   <= CCSM_SET_DEFAULT;
            activeSrc_q <= CCSM_SET_DEFAULT;
            booted_q    <= 1'b0;
        end else begin
            if (storeGo || restoreGo) begin
                xferSet_q <= cmdSlot;
            end
            if (lastIdx && state_q == CCSM_S_BOOT) begin
                activeSrc_q <= bootProfilePick;
                booted_q    <= 1'b1;
            end
            // RULE16 loaded slot now governs
            if (lastIdx && state_q == CCSM_S_LOAD) begin
                activeSrc_q <= xferSet_q;
            end
        end
    end

    // ==========================================
    // working set
    always_ff @(posedge clk) begin
        if (!resetn) begin
            // RULE1 volatile working set
            for (int i = 0; i < NUM_WORDS; i++) begin
                work_q[i] <= '0;
            end
        end else if (state_q == CCSM_S_BOOT || state_q == CCSM_S_LOAD) begin
            work_q[idx_q] <= srcWord;
        end else if (paramGo) begin
            // RULE2 writes reach working set
            work_q[IW'(wordOf(regAddr, `CCSM_OFS_PARAM))] <= regWrData[DW-1:0];
        end
    end

    // ==========================================
    // lookup table, kept out of user slots
    always_ff @(posedge clk) begin
        if (!resetn) begin
            // RULE15 table lost at reset
            for (int i = 0; i < LUT_WORDS; i++) begin
                lut_q[i] <= '0;
            end
        end else if (lutWr) begin
            lut_q[LW'(wordOf(regAddr, `CCSM_OFS_LUT))] <= regWrData[DW-1:0];
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_WORDS; i++) begin
            activeSet[i*DW +: DW] = work_q[i];
        end
        for (int i = 0; i < LUT_WORDS; i++) begin
            lutSet[i*DW +: DW] = lut_q[i];
        end
        setValid = booted_q;
    end

    // ==========================================
    // selector and refusal flag
    always_ff @(posedge clk) begin
        if (!resetn) begin
            profileSlotPick_q <= CCSM_SET_DEFAULT;
        end else if (ctrlWr) begin
            // RULE17 selector held for readback
            profileSlotPick_q <= cmdSlot;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reject_q <= 1'b0;
        end else if (rejectSet) begin
            // a new refusal beats a clear
            reject_q <= 1'b1;
        end else if (rejectClr) begin
            reject_q <= 1'b0;
        end
    end

    // ==========================================
    // read port
    always_comb begin
        rdData_d = '0;
        if (regRd) begin
            if (regAddr == `CCSM_OFS_CTRL) begin
                rdData_d[1:0] = profileSlotPick_q;
            end else if (regAddr == `CCSM_OFS_FACT) begin
                // RULE7 pick read from storage
                rdData_d[1:0] = factoryProfilePick;
            end else if (regAddr == `CCSM_OFS_BOOT) begin
                // RULE21 persistent startup pick
                rdData_d[1:0] = bootProfilePick;
            end else if (regAddr == `CCSM_OFS_STAT) begin
                rdData_d[`CCSM_ST_BUSY]   = busy;
                rdData_d[`CCSM_ST_REJECT] = reject_q;
                rdData_d[`CCSM_ST_BOOTED] = booted_q;
                rdData_d[`CCSM_ST_IDLE]   = acqIdle;
                rdData_d[`CCSM_ST_SRC +: 2] = activeSrc_q;
            end else if (inWin(regAddr, `CCSM_OFS_PARAM, NUM_WORDS)) begin
                rdData_d[DW-1:0] = work_q[IW'(wordOf(regAddr, `CCSM_OFS_PARAM))];
            end else if (inWin(regAddr, `CCSM_OFS_LUT, LUT_WORDS)) begin
                rdData_d[DW-1:0] = lut_q[LW'(wordOf(regAddr, `CCSM_OFS_LUT))];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= rdData_d;
        end
    end
    assign regRdData = rdData_q;
endmodule : ccsm_set_manager
`default_nettype wire

// ### test/ccsm_set_manager_chk.sv
// Purpose : port assertions of the set manager
// Assumes : bound to ccsm_set_manager, one clock
// Notes   : helper flops keep last address and data
`timescale 1ns/1ps
`default_nettype none
`include "ccsm_defs.svh"
module ccsm_set_manager_chk #(
    parameter int DW        = 16,
    parameter int NUM_WORDS = 8,
    parameter int LUT_WORDS = 4
) (
    input wire logic                    clk,
    input wire logic                    resetn,
    input wire logic                    nvFormat,
    input wire logic                    acqContinuous,
    input wire logic                    acqPending,
    input wire logic [7:0]              regAddr,
    input wire logic [31:0]             regWrData,
    input wire logic                    regWr,
    input wire logic                    regRd,
    input wire logic [31:0]             regRdData,
    input wire logic [NUM_WORDS*DW-1:0] activeSet,
    input wire logic [LUT_WORDS*DW-1:0] lutSet,
    input wire logic                    busy,
    input wire logic                    setValid
);
    logic [7:0]  aQ;
    logic [31:0] dQ;
    wire logic   ctlWr = regWr && regAddr == `CCSM_OFS_CTRL && !busy;
    wire logic   acq   = acqContinuous || acqPending;
    // ==========================================
    // helper
    always_ff @(posedge clk) begin
        aQ <= regAddr;
        dQ <= regWrData;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ==========================================
    // assertions
    a_read_zero: assert property (!$past(regRd) |-> regRdData == 32'h0000_0000)
        else $error("read data outside its cycle");
    a_boot_length: assert property ($rose(resetn) |-> busy ##1 busy[*7] ##[1:2] (!busy && setValid))
        else $error("startup load length wrong");
    a_restore_len: assert property (ctlWr && regWrData[5:4] == 2'b10 && !acq |=> busy[*8] ##1 !busy)
        else $error("restore length wrong");
    a_store_len: assert property (ctlWr && regWrData[5:4] == 2'b01 && regWrData[1:0] != 2'b00
                                  |=> busy[*8] ##1 !busy)
        else $error("store length wrong");
    a_acq_refuse: assert property (ctlWr && regWrData[5:4] == 2'b10 && acq |=> !busy && $stable(activeSet))
        else $error("restore taken while acquiring");
    a_slot0_refuse: assert property (ctlWr && regWrData[5:4] == 2'b01 && regWrData[1:0] == 2'b00 |=> !busy)
        else $error("store to slot zero taken");
    a_param_write: assert property (regWr && !busy && regAddr[7:5] == 3'b010 && regAddr[1:0] == 2'b00
                                    |=> activeSet[aQ[4:2]*DW +: DW] == dQ[DW-1:0])
        else $error("parameter write lost");
    a_lut_write: assert property (regWr && regAddr[7:4] == 4'h8 |=> lutSet[aQ[3:2]*DW +: DW] == dQ[DW-1:0])
        else $error("lookup write lost");
    a_set_hold: assert property (!busy && !regWr |=> $stable(activeSet))
        else $error("working set changed unasked");
    a_reset_clear: assert property ($rose(resetn) |-> activeSet == '0 && lutSet == '0 && !setValid)
        else $error("volatile state survived reset");
    a_valid_keep: assert property (setValid |=> setValid)
        else $error("valid flag dropped");
endmodule : ccsm_set_manager_chk
`default_nettype wire

// ### test/tb_ccsm_set_manager.sv
// Purpose : self-checking bench of the set manager
// Assumes : nvFormat held through the first reset
// Notes   : color profile contents are not checked
`timescale 1ns/1ps
`default_nettype none
`include "ccsm_defs.svh"
module tb_ccsm_set_manager;
    logic         clk           = 1'b0;
    logic         resetn        = 1'b0;
    logic         nvFormat      = 1'b1;
    logic         acqContinuous = 1'b0;
    logic         acqPending    = 1'b0;
    logic [7:0]   regAddr       = 8'h00;
    logic [31:0]  regWrData     = 32'h0000_0000;
    logic         regWr         = 1'b0;
    logic         regRd         = 1'b0;
    logic [31:0]  regRdData;
    logic [127:0] activeSet;
    logic [63:0]  lutSet;
    logic         busy;
    logic         setValid;
    int           error_cnt     = 0;
    int           n_checks      = 0;
    logic [31:0]  seed          = 32'h0000_000C;
    logic [31:0]  rv;
    logic [127:0] sv [4];
    ccsm_set_manager i_dut (
        .clk(clk), .resetn(resetn), .nvFormat(nvFormat), .acqContinuous(acqContinuous),
        .acqPending(acqPending), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .activeSet(activeSet), .lutSet(lutSet),
        .busy(busy), .setValid(setValid)
    );
    initial begin
        forever #2 clk = ~clk;
    end
    // ==========================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [127:0] prof(input int fp);
        logic [127:0] p;
        p          = '0;
        p[31:16]   = `CCSM_EXPO_STD;
        p[95:80]   = `CCSM_RATIO_ONE;
        p[111:96]  = `CCSM_RATIO_ONE;
        if (fp == 1)
            p[15:0] = `CCSM_GAIN_6DB;
        if (fp == 2)
            p[47:32] = `CCSM_AUTO_CONT;
        return p;
    endfunction : prof
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWr     <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd   <= 1'b0;
        #1 d = regRdData;
    endtask : rd
    task automatic idle();
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (busy === 1'b0)
                break;
        end
    endtask : idle
    task automatic run(input logic [31:0] d);
        wr(`CCSM_OFS_CTRL, d);
        idle();
    endtask : run
    task automatic boot(input logic fmt);
        @(posedge clk);
        resetn   <= 1'b0;
        nvFormat <= fmt;
        repeat (12) @(posedge clk);
        resetn   <= 1'b1;
        nvFormat <= 1'b0;
        idle();
    endtask : boot
    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    // ==========================================
    // main sequence
    initial begin
        boot(1'b1);
        sv[0] = prof(0);
        chk(activeSet, sv[0]);
        chk(128'(setValid), 128'h1);
        $display("delivery boot done");
        for (int f = 3; f >= 0; f--) begin
            wr(`CCSM_OFS_FACT, 32'(f));
            run(32'h0000_0020);
            if (f < 3)
                chk(activeSet, prof(f));
            rd(`CCSM_OFS_FACT, rv);
            chk(128'(rv), 128'(f));
        end
        $display("factory profiles done");
        for (int s = 1; s < 4; s++) begin
            sv[s] = '0;
            for (int w = 0; w < 7; w++) begin
                rv = xs();
                sv[s][w*16 +: 16] = rv[15:0];
                wr(8'h40 + 8'(4*w), {16'h0000, rv[15:0]});
            end
            #1;
            chk(activeSet, sv[s]);
            run(32'h0000_0010 | 32'(s));
        end
        run(32'h0000_0011);
        sv[1] = sv[3];
        for (int s = 1; s < 4; s++) begin
            run(32'h0000_0020 | 32'(s));
            chk(activeSet, sv[s]);
            rd(`CCSM_OFS_STAT, rv);
            chk(128'(rv[9:8]), 128'(s));
        end
        $display("user slots done");
        for (int m = 1; m < 3; m++) begin
            {acqPending, acqContinuous} <= 2'(m);
            wr(`CCSM_OFS_CTRL, 32'h0000_0020);
            wr(`CCSM_OFS_FACT, 32'h0000_0001);
            rd(`CCSM_OFS_FACT, rv);
            chk(128'(rv), 128'h0);
            chk(activeSet, sv[3]);
            rd(`CCSM_OFS_STAT, rv);
            chk(128'(rv[1]), 128'h1);
            wr(`CCSM_OFS_STAT, 32'h0000_0002);
        end
        {acqPending, acqContinuous} <= 2'b00;
        wr(`CCSM_OFS_CTRL, 32'h0000_0022);
        wr(`CCSM_OFS_CTRL, 32'h0000_0013);
        wr(8'h40, 32'h0000_FFFF);
        idle();
        chk(activeSet, sv[2]);
        wr(`CCSM_OFS_CTRL, 32'h0000_0010);
        run(32'h0000_0023);
        chk(activeSet, sv[3]);
        rd(8'h3C, rv);
        chk(128'(rv), 128'h0);
        $display("refusals done");
        for (int b = 3; b >= 0; b--) begin
            rv = xs();
            wr(`CCSM_OFS_LUT + 8'(4*b), rv);
            #1;
            chk(128'(lutSet[b*16 +: 16]), 128'(rv[15:0]));
            wr(`CCSM_OFS_BOOT, 32'(b));
            boot(1'b0);
            chk(activeSet, sv[b]);
            chk(128'(lutSet), 128'h0);
            rd(`CCSM_OFS_BOOT, rv);
            chk(128'(rv), 128'(b));
        end
        $display("startup picks done");
        summarize();
    end
endmodule : tb_ccsm_set_manager
bind ccsm_set_manager ccsm_set_manager_chk #(.DW(DW), .NUM_WORDS(NUM_WORDS), .LUT_WORDS(LUT_WORDS)) i_chk (
    .clk(clk), .resetn(resetn), .nvFormat(nvFormat), .acqContinuous(acqContinuous),
    .acqPending(acqPending), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .activeSet(activeSet), .lutSet(lutSet),
    .busy(busy), .setValid(setValid)
);
`default_nettype wire
